/* File: hdl/adc_defs.vh */
// Register map, field positions, reset values and timing counts
// Assumes inclusion by the antenna driver control design files and their checker and bench
`ifndef ADC_DEFS_VH
`define ADC_DEFS_VH
// ==========================================
// Register offsets
`define ADC_CTRL_ADDR        6'h14
`define ADC_AUTO_ADDR        6'h15
// ==========================================
// Control register fields
`define ADC_INV_B_ON         7
`define ADC_INV_A_ON         6
`define ADC_INV_B_OFF        5
`define ADC_INV_A_OFF        4
`define ADC_B_CW             3
`define ADC_CHECK_RF         2
`define ADC_B_EN             1
`define ADC_A_EN             0
`define ADC_CTRL_RESET       8'h80
// ==========================================
// Automation register fields
`define ADC_AUTO_OFF         7
`define ADC_FORCE_ASK        6
`define ADC_AUTO_WAKE        5
`define ADC_CA_ON            3
`define ADC_INIT_CA          2
`define ADC_B_AUTO           1
`define ADC_A_AUTO           0
`define ADC_AUTO_RESET       8'h00
`define ADC_AUTO_MASK        8'hEF
// ==========================================
// Timing and protocol constants
`define ADC_CLK_MHZ          25
`define ADC_CARRIER_KHZ      13560
`define ADC_ACTIVE_DELAY_TIME_CYCLES      1024
`define ADC_INITIAL_DELAY_TIME_CYCLES      4096
`define ADC_CA_SLOT_N        2'h3
`define ADC_DIV_ACC_W        16
`endif

/* File: hdl/adc_carrier_tick.v */
// Fractional divider giving one enable pulse per carrier period
// Assumes one core clock; accumulator step set for the carrier and core rates
`timescale 1ns/1ps
`include "adc_defs.vh"
module adc_carrier_tick #(
  parameter CORE_KHZ    = 25000,
  parameter CARRIER_KHZ = `ADC_CARRIER_KHZ
) (
  input  wire core_clk,
  input  wire rst,
  output reg  tick
);
  // ==========================================
  // Phase accumulator
  localparam [`ADC_DIV_ACC_W-1:0] STEP = CARRIER_KHZ[`ADC_DIV_ACC_W-1:0];
  localparam [`ADC_DIV_ACC_W-1:0] WRAP = CORE_KHZ[`ADC_DIV_ACC_W-1:0];
  reg  [`ADC_DIV_ACC_W-1:0] acc;
  wire [`ADC_DIV_ACC_W:0]   sum = {1'b0, acc} + {1'b0, STEP};

  always @(posedge core_clk) begin
    if (rst) begin
      acc  <= 16'h0000;
      tick <= 1'b0;
    end else if (sum >= {1'b0, WRAP}) begin
      acc  <= sum[`ADC_DIV_ACC_W-1:0] - WRAP;
      tick <= 1'b1;
    end else begin
      acc  <= sum[`ADC_DIV_ACC_W-1:0];
      tick <= 1'b0;
    end
  end
endmodule

/* File: hdl/adc_antenna_driver.v */
// Antenna driver control: two registers, driver output logic, auto turn-on
// Assumes field, envelope and end-of-transmit signals arrive from pins or other logic
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ps
`include "adc_defs.vh"
module adc_antenna_driver #(
  parameter ACTIVE_DELAY  = `ADC_ACTIVE_DELAY_TIME_CYCLES,
  parameter INITIAL_DELAY = `ADC_INITIAL_DELAY_TIME_CYCLES,
  parameter CNT_W         = 16
) (
  input  wire       core_clk,
  input  wire       rst,
  input  wire [5:0] reg_addr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_wr,
  input  wire       reg_rd,
  output reg  [7:0] reg_rdata,
  input  wire       ext_field_pin,
  input  wire       level_detect_pin,
  input  wire       tx_envelope,
  input  wire       tx_last_bit_done,
  input  wire [1:0] driver_source_select,
  input  wire       soft_powerdown,
  output reg        antenna_output_a,
  output reg        antenna_output_b,
  output reg        field_wake,
  output reg        force_full_depth_ask,
  output reg        collision_avoidance_on,
  output reg  [1:0] ca_slot_n
);
  // ==========================================
  // Pin synchronisers
  reg [1:0] field_sync;
  reg [1:0] level_sync;
  reg       level_prev;
  wire      field = field_sync[1];
  wire      level_rise = level_sync[1] & ~level_prev;

  // Field presence: two flip-flops, nothing reads the first
  always @(posedge core_clk) begin
    if (rst) begin
      field_sync <= 2'b00;
    end else begin
      field_sync <= {field_sync[0], ext_field_pin};
    end
  end

  // Level detector: same two-stage guard before the edge finder
  always @(posedge core_clk) begin
    if (rst) begin
      level_sync <= 2'b00;
    end else begin
      level_sync <= {level_sync[0], level_detect_pin};
    end
  end

  // Starts low like the idle pin, so no false edge follows reset
  always @(posedge core_clk) begin
    if (rst) begin
      level_prev <= 1'b0;
    end else begin
      level_prev <= level_sync[1];
    end
  end

  // ==========================================
  // Carrier rate enable
  wire carrier_tick;
  adc_carrier_tick #(
    .CORE_KHZ    (`ADC_CLK_MHZ * 1000),
    .CARRIER_KHZ (`ADC_CARRIER_KHZ)
  ) u_tick (
    .core_clk (core_clk),
    .rst      (rst),
    .tick     (carrier_tick)
  );

  // ==========================================
  // Registers
  reg  [7:0] ctrl;
  reg  [7:0] autoc;
  wire       wr_ctrl = reg_wr & (reg_addr == `ADC_CTRL_ADDR);
  wire       wr_auto = reg_wr & (reg_addr == `ADC_AUTO_ADDR);
  wire       any_on  = ctrl[`ADC_B_EN] | ctrl[`ADC_A_EN];

  // Auto turn-on sequencer states
  localparam [3:0] ST_IDLE  = 4'b0001;
  localparam [3:0] ST_FIELD = 4'b0010;
  localparam [3:0] ST_WAIT  = 4'b0100;
  localparam [3:0] ST_INIT  = 4'b1000;
  reg  [3:0]       state;
  reg  [3:0]       next_state;
  reg  [CNT_W-1:0] cnt;
  reg  [CNT_W-1:0] next_cnt;
  reg              auto_fire;

  localparam integer     ACTIVE_DELAY_TIME_INT  = ACTIVE_DELAY - 1;
  localparam integer     INITIAL_DELAY_TIME_INT  = INITIAL_DELAY - 1;
  localparam [CNT_W-1:0] ACTIVE_DELAY_TIME_LAST = ACTIVE_DELAY_TIME_INT[CNT_W-1:0];
  localparam [CNT_W-1:0] INITIAL_DELAY_TIME_LAST = INITIAL_DELAY_TIME_INT[CNT_W-1:0];

  // ==========================================
  // Delay window compare
  // Final count of a delay window, checked only on a carrier tick
  function delay_done;
    input [CNT_W-1:0] count;
    input [CNT_W-1:0] last;
    begin
      delay_done = (count == last);
    end
  endfunction

  // Enable bits after a write, with field check applied
  function [1:0] gate_enables;
    input [1:0] old_en;
    input [1:0] new_en;
    input       check;
    input       fld;
    begin
      if (check & fld)
        gate_enables = new_en & old_en;
      else
        gate_enables = new_en;
    end
  endfunction

  // ==========================================
  // Register write path
  // Next register values, lowest priority first:
  // host write, then auto-off, then auto turn-on
  reg  [7:0] next_ctrl;
  reg  [7:0] next_autoc;
  wire       init_done = autoc[`ADC_INIT_CA] & auto_fire & (autoc[1:0] != 2'b00);

  always @* begin
    next_ctrl  = ctrl;
    next_autoc = autoc;
    if (wr_ctrl) begin
      // Field check bit is write-only and only acts on this write
      next_ctrl[7:3]           = reg_wdata[7:3];
      next_ctrl[`ADC_CHECK_RF] = 1'b0;
      next_ctrl[1:0]           = gate_enables(ctrl[1:0], reg_wdata[1:0],
                                              reg_wdata[`ADC_CHECK_RF], field);
    end
    if (tx_last_bit_done & autoc[`ADC_AUTO_OFF]) begin
      next_ctrl[1:0] = 2'b00;
    end
    if (auto_fire) begin
      next_ctrl[1:0] = ctrl[1:0] | autoc[1:0];
    end
    if (wr_auto) begin
      next_autoc = reg_wdata & `ADC_AUTO_MASK;
    end
    // Hardware clear beats a same-cycle write only once carrier is on
    if (init_done) begin
      next_autoc[`ADC_INIT_CA] = 1'b0;
    end
  end

  always @(posedge core_clk) begin
    if (rst) begin
      ctrl  <= `ADC_CTRL_RESET;
      autoc <= `ADC_AUTO_RESET;
    end else begin
      ctrl  <= next_ctrl;
      autoc <= next_autoc;
    end
  end

  // ==========================================
  // Auto turn-on sequencer, counting carrier cycles
  always @* begin
    next_state = state;
    next_cnt   = cnt;
    auto_fire  = 1'b0;
    case (state)
      ST_IDLE: begin
        next_cnt = {CNT_W{1'b0}};
        if (autoc[`ADC_INIT_CA] & !field & !any_on)
          next_state = ST_INIT;
        else if (field & (autoc[1:0] != 2'b00))
          next_state = ST_FIELD;
      end
      ST_FIELD: begin
        next_cnt = {CNT_W{1'b0}};
        if (!field)
          next_state = ST_WAIT;
      end
      ST_WAIT: begin
        if (field) begin
          next_state = ST_FIELD;
        end else if (carrier_tick) begin
          if (delay_done(cnt, ACTIVE_DELAY_TIME_LAST)) begin
            auto_fire  = 1'b1;
            next_state = ST_IDLE;
          end else begin
            next_cnt = cnt + 1'b1;
          end
        end
      end
      ST_INIT: begin
        if (field) begin
          next_cnt   = {CNT_W{1'b0}};
          next_state = ST_FIELD;
        end else if (!autoc[`ADC_INIT_CA]) begin
          next_state = ST_IDLE;
        end else if (carrier_tick) begin
          if (delay_done(cnt, INITIAL_DELAY_TIME_LAST)) begin
            auto_fire  = 1'b1;
            next_state = ST_IDLE;
          end else begin
            next_cnt = cnt + 1'b1;
          end
        end
      end
      default: begin
        next_state = ST_IDLE;
        next_cnt   = {CNT_W{1'b0}};
      end
    endcase
  end

  // ==========================================
  // Sequencer registers
  always @(posedge core_clk) begin
    if (rst) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Counter kept apart from the state so its width can grow alone
  always @(posedge core_clk) begin
    if (rst) begin
      cnt <= {CNT_W{1'b0}};
    end else begin
      cnt <= next_cnt;
    end
  end

  // ==========================================
  // Driver outputs
  // Source: 00 off, 01/10 envelope (driver B steady high when ADC_B_CW is set), 11 forced high
  function drive_level;
    input       en;
    input       inv_on;
    input       inv_off;
    input       cw;
    input [1:0] src;
    input       env;
    reg         raw;
    begin
      raw = 1'b0;
      if (en) begin
        if (src == 2'b11)
          raw = 1'b1;
        else if (cw)
          raw = (src != 2'b00);
        else
          raw = (src != 2'b00) & env;
        drive_level = raw ^ inv_on;
      end else begin
        drive_level = raw ^ inv_off;
      end
    end
  endfunction

  // Next driver levels
  wire next_out_a = drive_level(ctrl[`ADC_A_EN], ctrl[`ADC_INV_A_ON],
                                ctrl[`ADC_INV_A_OFF], 1'b0,
                                driver_source_select, tx_envelope);
  wire next_out_b = drive_level(ctrl[`ADC_B_EN], ctrl[`ADC_INV_B_ON],
                                ctrl[`ADC_INV_B_OFF], ctrl[`ADC_B_CW],
                                driver_source_select, tx_envelope);

  always @(posedge core_clk) begin
    if (rst) begin
      antenna_output_a <= 1'b0;
      antenna_output_b <= 1'b0;
    end else begin
      antenna_output_a <= next_out_a;
      antenna_output_b <= next_out_b;
    end
  end

  // ==========================================
  // Status outputs
  // One-cycle wake pulse on a level detector rising edge
  always @(posedge core_clk) begin
    if (rst) begin
      field_wake <= 1'b0;
    end else begin
      field_wake <= autoc[`ADC_AUTO_WAKE] & soft_powerdown & level_rise;
    end
  end

  always @(posedge core_clk) begin
    if (rst) begin
      force_full_depth_ask   <= 1'b0;
      collision_avoidance_on <= 1'b0;
      ca_slot_n              <= 2'b00;
    end else begin
      force_full_depth_ask   <= autoc[`ADC_FORCE_ASK];
      collision_avoidance_on <= autoc[`ADC_CA_ON];
      ca_slot_n <= autoc[`ADC_CA_ON] ? `ADC_CA_SLOT_N : 2'b00;
    end
  end

  // ==========================================
  // Register read port
  // Unmapped offsets and idle cycles read as zero
  function [7:0] read_value;
    input [5:0] addr;
    input [7:0] c;
    input [7:0] a;
    begin
      if (addr == `ADC_CTRL_ADDR)
        read_value = c;
      else if (addr == `ADC_AUTO_ADDR)
        read_value = a;
      else
        read_value = 8'h00;
    end
  endfunction

  always @(posedge core_clk) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= read_value(reg_addr, ctrl, autoc);
    end else begin
      reg_rdata <= 8'h00;
    end
  end
endmodule

/* File: tb/adc_field_model.sv */
// External RF field as the antenna pins see it
// Assumes field_req and slow come from the bench
`timescale 1ns/1ps
module adc_field_model (
  input  wire core_clk,
  input  wire field_req,
  input  wire slow,
  output wire ext_field_pin,
  output wire level_detect_pin
);
  // ==========
  // Field build-up
  reg [3:0] dly = 4'h0;
  always @(posedge core_clk) begin
    dly <= {dly[2:0], field_req};
  end
  // A slow peer takes several cycles to raise or drop its field
  assign ext_field_pin    = slow ? dly[3] : dly[0];
  assign level_detect_pin = ext_field_pin;
endmodule

/* File: tb/adc_drv_chk.sv */
// Checker on register reads and status outputs
// Assumes it is bound to the driver control top
`timescale 1ns/1ps
`include "adc_defs.vh"
module adc_drv_chk (
  input wire       core_clk,
  input wire       rst,
  input wire [5:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire       reg_wr,
  input wire       reg_rd,
  input wire [7:0] reg_rdata,
  input wire       soft_powerdown,
  input wire       field_wake,
  input wire       force_full_depth_ask,
  input wire       collision_avoidance_on,
  input wire [1:0] ca_slot_n
);
  // ==========
  // Properties
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  wire wa = reg_wr && reg_addr == `ADC_AUTO_ADDR;
  wire rc = reg_rd && reg_addr == `ADC_CTRL_ADDR;
  wire ra = reg_rd && reg_addr == `ADC_AUTO_ADDR;
  a_rdata_idle: assert property (!$past(rc || ra) |-> reg_rdata == 8'h00)
    else $error("read data not zero");
  a_check_bit_reads: assert property ($past(rc) |-> !reg_rdata[`ADC_CHECK_RF])
    else $error("write-only bit read back");
  a_rfu_bit_reads: assert property ($past(ra) |-> !reg_rdata[4])
    else $error("reserved bit read back");
  a_ask_follows: assert property (wa ##1 !wa |->
    ##1 force_full_depth_ask == $past(reg_wdata[`ADC_FORCE_ASK], 2))
    else $error("full ask output wrong");
  a_ca_follows: assert property (wa ##1 !wa |->
    ##1 collision_avoidance_on == $past(reg_wdata[`ADC_CA_ON], 2))
    else $error("avoidance output wrong");
  a_slot_value: assert property (ca_slot_n == (collision_avoidance_on ? 2'h3 : 2'h0))
    else $error("slot value wrong");
  a_wake_pulse: assert property (field_wake |=> !field_wake)
    else $error("wake longer than a cycle");
  a_wake_in_pd: assert property (field_wake |-> $past(soft_powerdown))
    else $error("wake outside power-down");
endmodule

/* File: tb/test_adc_antenna_driver.sv */
// Bench for the antenna driver control block
// Assumes the field model and checker compile first
`timescale 1ns/1ps
`include "adc_defs.vh"
module test_adc_antenna_driver;
  localparam [5:0] CT = `ADC_CTRL_ADDR;
  localparam [5:0] AU = `ADC_AUTO_ADDR;
  reg         core_clk  = 1'b0;
  reg         rst       = 1'b1;
  reg  [5:0]  reg_addr  = 6'h00;
  reg  [7:0]  reg_wdata = 8'h00;
  reg         reg_wr    = 1'b0;
  reg         reg_rd    = 1'b0;
  reg         env       = 1'b0;
  reg         last      = 1'b0;
  reg  [1:0]  src       = 2'h1;
  reg         pd        = 1'b0;
  reg         fld_req   = 1'b0;
  reg         slow      = 1'b0;
  wire [7:0]  reg_rdata;
  wire        ext_f, lvl, out_a, out_b, wake, ask, ca;
  wire [1:0]  slot;
  reg  [7:0]  rv;
  reg  [12:0] rows [0:8];
  integer     failures = 0, num_checks = 0, i, n;
  // ==========
  // Clock, instances, tasks
  always #20 core_clk = ~core_clk;
  // Short delays keep the auto turn-on waits brief
  adc_antenna_driver #(.ACTIVE_DELAY(4), .INITIAL_DELAY(8)) DUT (
    .core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_field_pin(ext_f),
    .level_detect_pin(lvl), .tx_envelope(env), .tx_last_bit_done(last),
    .driver_source_select(src), .soft_powerdown(pd), .antenna_output_a(out_a),
    .antenna_output_b(out_b), .field_wake(wake), .force_full_depth_ask(ask),
    .collision_avoidance_on(ca), .ca_slot_n(slot));
  adc_field_model fld (.core_clk(core_clk), .field_req(fld_req), .slow(slow),
    .ext_field_pin(ext_f), .level_detect_pin(lvl));
  task chk(input [7:0] seen, input [7:0] exp);
    begin
      num_checks = num_checks + 1;
      if (seen !== exp) begin
        failures = failures + 1;
        $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
    end
  endtask
  task final_report;
    begin
      if (failures == 0 && num_checks > 0) begin
        $display("Simulation passed");
      end else begin
        $display("Simulation failed");
      end
      $finish;
    end
  endtask
  task wr(input [5:0] a, input [7:0] d);
    begin
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge core_clk);
      reg_wr    <= 1'b0;
      @(posedge core_clk);
    end
  endtask
  task rd(input [5:0] a);
    begin
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge core_clk);
      reg_rd   <= 1'b0;
      #1 rv = reg_rdata;
      @(posedge core_clk);
    end
  endtask
  // Polls the control register until all bits of m are set
  task wait_ctrl(input [7:0] m);
    begin
      n = 0;
      rd(CT);
      while ((rv & m) !== m && n < 60) begin
        rd(CT);
        n = n + 1;
      end
      chk(rv & m, m);
      if (n == 60) final_report;
    end
  endtask
  // ==========
  // Main sequence
  initial begin
    rows[0] = {8'h80, 2'h1, 1'b1, 2'b00};
    rows[1] = {8'h30, 2'h1, 1'b0, 2'b11};
    rows[2] = {8'h03, 2'h1, 1'b1, 2'b11};
    rows[3] = {8'h03, 2'h2, 1'b0, 2'b00};
    rows[4] = {8'hc3, 2'h1, 1'b1, 2'b00};
    rows[5] = {8'h0b, 2'h1, 1'b0, 2'b01};
    rows[6] = {8'h43, 2'h3, 1'b0, 2'b01};
    rows[7] = {8'h07, 2'h1, 1'b1, 2'b11};
    rows[8] = {8'h31, 2'h3, 1'b0, 2'b11};
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    rd(CT);
    chk(rv, `ADC_CTRL_RESET);
    rd(AU);
    chk(rv, `ADC_AUTO_RESET);
    rd(6'h16);
    chk(rv, 8'h00);
    for (i = 0; i < 9; i = i + 1) begin
      src <= rows[i][4:3];
      env <= rows[i][2];
      wr(CT, rows[i][12:5]);
      rd(CT);
      chk(rv, rows[i][12:5] & 8'hfb);
      chk({6'h00, out_a, out_b}, {6'h00, rows[i][1:0]});
    end
    wr(AU, 8'h78);
    rd(AU);
    chk(rv, 8'h68);
    chk({4'h0, ask, ca, slot}, 8'h0f);
    pd      <= 1'b1;
    slow    <= 1'b1;
    fld_req <= 1'b1;
    n = 0;
    while (wake !== 1'b1 && n < 20) begin
      @(posedge core_clk);
      #1 n = n + 1;
    end
    chk({7'h00, wake}, 8'h01);
    if (n == 20) final_report;
    @(posedge core_clk);
    fld_req <= 1'b0;
    slow    <= 1'b0;
    wr(AU, 8'h00);
    wr(CT, 8'h00);
    pd      <= 1'b0;
    fld_req <= 1'b1;
    repeat (6) @(posedge core_clk);
    wr(CT, 8'h07);
    rd(CT);
    chk(rv, 8'h00);
    wr(CT, 8'h03);
    rd(CT);
    chk(rv, 8'h03);
    wr(AU, 8'h80);
    last <= 1'b1;
    @(posedge core_clk);
    last <= 1'b0;
    rd(CT);
    chk(rv, 8'h00);
    wr(AU, 8'h03);
    fld_req <= 1'b0;
    repeat (3) @(posedge core_clk);
    rd(CT);
    chk(rv, 8'h00);
    wait_ctrl(8'h03);
    wr(CT, 8'h00);
    fld_req <= 1'b1;
    wr(AU, 8'h05);
    repeat (30) @(posedge core_clk);
    rd(CT);
    chk(rv, 8'h00);
    fld_req <= 1'b0;
    wait_ctrl(8'h01);
    chk(rv & 8'h03, 8'h01);
    rd(AU);
    chk(rv, 8'h01);
    wr(CT, 8'h00);
    wr(AU, 8'h06);
    rd(CT);
    chk(rv, 8'h00);
    wait_ctrl(8'h02);
    rd(AU);
    chk(rv, 8'h02);
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    rd(CT);
    chk(rv, `ADC_CTRL_RESET);
    rd(AU);
    chk(rv, `ADC_AUTO_RESET);
    chk({6'h00, out_a, out_b}, 8'h00);
    final_report;
  end
endmodule
bind adc_antenna_driver adc_drv_chk u_chk (.core_clk(core_clk), .rst(rst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .soft_powerdown(soft_powerdown), .field_wake(field_wake),
  .force_full_depth_ask(force_full_depth_ask),
  .collision_avoidance_on(collision_avoidance_on), .ca_slot_n(ca_slot_n));
